/* File: core_regs_map.svh */
// Special function register offsets, field positions and reset values
`ifndef CORE_REGS_MAP_SVH
`define CORE_REGS_MAP_SVH

`define OFF_STACK_POINTER    8'h81
`define OFF_PTR0_LOW         8'h82
`define OFF_PTR0_HIGH        8'h83
`define OFF_PTR1_LOW         8'h84
`define OFF_PTR1_HIGH        8'h85
`define OFF_CPU_MODE_SELECT  8'h86
`define OFF_PROGRAM_STATUS   8'hD0
`define OFF_ACCUMULATOR      8'hE0
`define OFF_B_REGISTER       8'hF0
`define OFF_AUX_OPERAND      8'hF1
`define OFF_EXT_RAM_PAGE     8'hF7

`define RST_STACK_POINTER    8'h07
`define RST_BYTE             8'h00

`define BIT_CARRY            7
`define BIT_HALF_CARRY       6
`define BIT_USER_ZERO        5
`define BIT_BANK_HI          4
`define BIT_BANK_LO          3
`define BIT_OVERFLOW         2
`define BIT_USER_ONE         1
`define BIT_PARITY           0

`define BIT_DIV_MODE         3
`define BIT_MUL_MODE         2
`define BIT_PTR_SELECT       0
`define MASK_CPU_MODE        8'h0D
`define MASK_EXT_PAGE        8'h7F
`define MASK_STATUS_WR       8'hFE

`define SFR_SPACE_BASE       8'h80
`define EXT_DISPLAY_BASE     16'h0500
`define EXT_DISPLAY_LAST     16'h051F
`define EXT_GENERAL_BYTES    16'h0500

`endif

/* File: core_regs_pkg.sv */
// Types shared by the core register block
package core_regs_pkg;

    typedef enum logic [1:0] {
        md_idle,
        md_mul,
        md_div
    } md_op_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

    typedef struct packed {
        logic we;
        logic cy;
        logic ac;
        logic ov;
    } flag_upd_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        in_range;
        logic        display;
    } ext_addr_s;

endpackage : core_regs_pkg

/* File: cpu_core_registers_muldiv.sv */
// Core processor registers, multiply/divide datapath and address mapping
// Function
// RULE1: 8-bit stack pointer, increment before push write
// RULE2: Pop reads at pointer, then decrements
// RULE3: Reset loads stack pointer with 07H
// RULE4: Bit 7 carry follows operation carry/borrow
// RULE5: Bit 6 records auxiliary carry or borrow
// RULE6: Bits 4-3 select working register bank
// RULE7: Bit 2 overflow follows operation overflow
// RULE8: Bit 0 read-only accumulator odd parity
// RULE9: Bits 5 and 1 are plain user flags
// RULE10: Data pointers usable as 16 or 8 bits
// RULE11: Reset leaves multiply/divide in 8-bit mode
// RULE12: 8-bit multiply: low in A, high in B
// RULE13: 16-bit multiply: low A, middle B, high aux
// RULE14: 8-bit divide: quotient A, remainder B
// RULE15: 16-bit divide: quotient split A/aux, remainder B
// RULE16: Pointer instructions use the selected pointer
// RULE17: Select bit 0 chooses primary or second
// RULE18: Software writes 0 to mode bit 6
// RULE19: Lower 128 bytes direct and indirect reachable
// RULE20: Upper addresses: indirect RAM, direct SFR
// RULE21: Page register supplies high byte for @Ri
// RULE22: 1280 general bytes plus display at 500H-51FH
`timescale 1ns/10ps
`include "core_regs_map.svh"

module cpu_core_registers_muldiv
    import core_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Special function register access
    input  wire sfr_req_s    sfr_req,
    output logic [7:0]       sfr_rdata,
    output logic             sfr_hit,
    // Stack operations
    input  wire logic        stack_push,
    input  wire logic        stack_pop,
    output logic [7:0]       stack_addr,
    // Flag updates from the arithmetic unit
    input  wire flag_upd_s   flag_upd,
    // Multiply and divide
    input  wire md_op_e      md_op,
    output logic             md_done,
    // Data pointer operations
    input  wire logic        ptr_inc,
    input  wire logic        ptr_load,
    input  wire logic [15:0] ptr_load_val,
    output logic [15:0]      active_ptr,
    // Internal RAM addressing
    input  wire logic [7:0]  int_addr,
    input  wire logic        int_indirect,
    input  wire logic [2:0]  work_reg_idx,
    output logic             int_to_sfr,
    output logic [7:0]       work_reg_addr,
    // External RAM addressing
    input  wire logic [15:0] ext_in_addr,
    input  wire logic        ext_via_page,
    output ext_addr_s        ext_addr,
    // Core register views
    output logic [7:0]       accumulator,
    output logic [7:0]       program_status_word
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]  stack_pointer;
    logic [7:0]  b_reg;
    logic [7:0]  aux_operand_byte;
    logic [15:0] primary_data_pointer;
    logic [15:0] second_data_pointer;
    logic [7:0]  cpu_mode_select;
    logic [7:0]  external_ram_page;
    logic        carry_flag;
    logic        half_carry_flag;
    logic        user_flag_zero;
    logic [1:0]  bank_select_field;
    logic        overflow_flag;
    logic        user_flag_one;
    logic        parity_flag;
    logic        pointer_select_bit;
    logic        multiply_mode_bit;
    logic        divide_mode_bit;
    function automatic logic sfr_wr_at(input sfr_req_s r,
                                       input logic [7:0] off);
        sfr_wr_at = r.wr && (r.addr == off);
    endfunction : sfr_wr_at
    assign pointer_select_bit = cpu_mode_select[`BIT_PTR_SELECT];
    assign multiply_mode_bit  = cpu_mode_select[`BIT_MUL_MODE];
    assign divide_mode_bit    = cpu_mode_select[`BIT_DIV_MODE];
    assign parity_flag        = ^accumulator; // RULE8

    assign program_status_word = {carry_flag, half_carry_flag,
                                  user_flag_zero, bank_select_field,
                                  overflow_flag, user_flag_one,
                                  parity_flag};

    ////////////////////////////////////////////////////////////////////////
    // Multiply / divide datapath
    logic [23:0] md_product;
    logic [15:0] md_quot;
    logic [7:0]  md_rem;
    logic        md_div_zero;

    assign md_div_zero = (b_reg == 8'h00);

    always_comb begin
        md_quot = 16'h0000;
        md_rem  = 8'h00;
        if (multiply_mode_bit)
            md_product = {8'h00, aux_operand_byte, accumulator} // RULE13
                       * {16'h0000, b_reg};
        else
            md_product = {16'h0000, accumulator} * {16'h0000, b_reg}; // RULE12
        if (!md_div_zero && divide_mode_bit) begin
            md_quot = {aux_operand_byte, accumulator} // RULE15
                    / {8'h00, b_reg};
            md_rem  = 8'({aux_operand_byte, accumulator}
                         % {8'h00, b_reg});
        end else if (!md_div_zero) begin
            md_quot = {8'h00, accumulator / b_reg}; // RULE14
            md_rem  = accumulator % b_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, B and auxiliary byte
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accumulator      <= `RST_BYTE;
            b_reg            <= `RST_BYTE;
            aux_operand_byte <= `RST_BYTE;
        end else if (md_op == md_mul) begin
            accumulator <= md_product[7:0];                  // RULE12
            b_reg       <= md_product[15:8];
            if (multiply_mode_bit)
                aux_operand_byte <= md_product[23:16];       // RULE13
        end else if (md_op == md_div) begin
            accumulator <= md_quot[7:0];                     // RULE14
            b_reg       <= md_rem;
            if (divide_mode_bit)
                aux_operand_byte <= md_quot[15:8];           // RULE15
        end else begin
            if (sfr_wr_at(sfr_req, `OFF_ACCUMULATOR))
                accumulator <= sfr_req.wdata;
            if (sfr_wr_at(sfr_req, `OFF_B_REGISTER))
                b_reg <= sfr_req.wdata;
            if (sfr_wr_at(sfr_req, `OFF_AUX_OPERAND))
                aux_operand_byte <= sfr_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            md_done <= 1'b0;
        end else begin
            md_done <= (md_op != md_idle);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program status word
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            carry_flag        <= 1'b0;
            half_carry_flag   <= 1'b0;
            user_flag_zero    <= 1'b0;
            bank_select_field <= 2'b00;
            overflow_flag     <= 1'b0;
            user_flag_one     <= 1'b0;
        end else begin
            if (sfr_wr_at(sfr_req, `OFF_PROGRAM_STATUS)) begin
                carry_flag        <= sfr_req.wdata[`BIT_CARRY];
                half_carry_flag   <= sfr_req.wdata[`BIT_HALF_CARRY];
                user_flag_zero    <= sfr_req.wdata[`BIT_USER_ZERO]; // RULE9
                bank_select_field <= sfr_req.wdata[`BIT_BANK_HI:`BIT_BANK_LO];
                overflow_flag     <= sfr_req.wdata[`BIT_OVERFLOW];
                user_flag_one     <= sfr_req.wdata[`BIT_USER_ONE];  // RULE9
            end
            if (flag_upd.we) begin
                carry_flag      <= flag_upd.cy;                 // RULE4
                half_carry_flag <= flag_upd.ac;                 // RULE5
                overflow_flag   <= flag_upd.ov;                 // RULE7
            end
            if (md_op == md_mul) begin
                carry_flag    <= 1'b0;
                overflow_flag <= multiply_mode_bit              // RULE7
                               ? (md_product[23:16] != 8'h00)
                               : (md_product[15:8] != 8'h00);
            end else if (md_op == md_div) begin
                carry_flag    <= 1'b0;
                overflow_flag <= md_div_zero;                   // RULE7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer
    assign stack_addr = stack_push ? stack_pointer + 8'h01   // RULE1
                                   : stack_pointer;          // RULE2

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stack_pointer <= `RST_STACK_POINTER;             // RULE3
        end else if (stack_push) begin
            stack_pointer <= stack_pointer + 8'h01;          // RULE1
        end else if (stack_pop) begin
            stack_pointer <= stack_pointer - 8'h01;          // RULE2
        end else if (sfr_wr_at(sfr_req, `OFF_STACK_POINTER)) begin
            stack_pointer <= sfr_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pointers
    assign active_ptr = pointer_select_bit ? second_data_pointer  // RULE17
                                           : primary_data_pointer;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            primary_data_pointer <= 16'h0000;
            second_data_pointer  <= 16'h0000;
        end else if (ptr_load || ptr_inc) begin
            if (pointer_select_bit) begin                          // RULE16
                second_data_pointer <= ptr_load ? ptr_load_val
                                     : second_data_pointer + 16'h0001;
            end else begin
                primary_data_pointer <= ptr_load ? ptr_load_val
                                      : primary_data_pointer + 16'h0001;
            end
        end else begin
            if (sfr_wr_at(sfr_req, `OFF_PTR0_LOW))                 // RULE10
                primary_data_pointer[7:0] <= sfr_req.wdata;
            if (sfr_wr_at(sfr_req, `OFF_PTR0_HIGH))                // RULE10
                primary_data_pointer[15:8] <= sfr_req.wdata;
            if (sfr_wr_at(sfr_req, `OFF_PTR1_LOW))
                second_data_pointer[7:0] <= sfr_req.wdata;
            if (sfr_wr_at(sfr_req, `OFF_PTR1_HIGH))
                second_data_pointer[15:8] <= sfr_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and page registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_mode_select <= `RST_BYTE;                          // RULE11
        end else if (sfr_wr_at(sfr_req, `OFF_CPU_MODE_SELECT)) begin
            cpu_mode_select <= sfr_req.wdata & `MASK_CPU_MODE;     // RULE18
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            external_ram_page <= `RST_BYTE;
        end else if (sfr_wr_at(sfr_req, `OFF_EXT_RAM_PAGE)) begin
            external_ram_page <= sfr_req.wdata & `MASK_EXT_PAGE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read-back
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else if (sfr_req.rd) begin
            sfr_hit <= 1'b1;
            unique case (sfr_req.addr)
                `OFF_STACK_POINTER:   sfr_rdata <= stack_pointer;
                `OFF_PTR0_LOW:        sfr_rdata <= primary_data_pointer[7:0];
                `OFF_PTR0_HIGH:       sfr_rdata <= primary_data_pointer[15:8];
                `OFF_PTR1_LOW:        sfr_rdata <= second_data_pointer[7:0];
                `OFF_PTR1_HIGH:       sfr_rdata <= second_data_pointer[15:8];
                `OFF_CPU_MODE_SELECT: sfr_rdata <= cpu_mode_select;
                `OFF_PROGRAM_STATUS:  sfr_rdata <= program_status_word;
                `OFF_ACCUMULATOR:     sfr_rdata <= accumulator;
                `OFF_B_REGISTER:      sfr_rdata <= b_reg;
                `OFF_AUX_OPERAND:     sfr_rdata <= aux_operand_byte;
                `OFF_EXT_RAM_PAGE:    sfr_rdata <= external_ram_page;
                default: begin
                    sfr_rdata <= 8'h00;
                    sfr_hit   <= 1'b0;
                end
            endcase
        end else begin
            sfr_hit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal and external address mapping
    assign int_to_sfr    = (int_addr >= `SFR_SPACE_BASE)        // RULE20
                        && !int_indirect;                        // RULE19
    assign work_reg_addr = {3'b000, bank_select_field,           // RULE6
                            work_reg_idx};

    always_comb begin
        ext_addr.addr = ext_via_page
                      ? {external_ram_page, ext_in_addr[7:0]}   // RULE21
                      : ext_in_addr;
        ext_addr.display  = (ext_addr.addr >= `EXT_DISPLAY_BASE)    // RULE22
                         && (ext_addr.addr <= `EXT_DISPLAY_LAST);
        ext_addr.in_range = (ext_addr.addr < `EXT_GENERAL_BYTES)
                         || ext_addr.display;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence push_seq;
        stack_push && !stack_pop;
    endsequence
    sequence pop_seq;
        stack_pop && !stack_push;
    endsequence

    stack_push_a: assert property (push_seq // RULE1
        |-> (stack_addr == stack_pointer + 8'h01)
            ##1 (stack_pointer == $past(stack_addr)))
        else $error("push did not pre-increment");
    stack_pop_a: assert property (pop_seq // RULE2
        |-> (stack_addr == stack_pointer)
            ##1 (stack_pointer == $past(stack_addr) - 8'h01))
        else $error("pop did not post-decrement");
    stack_reset_a: assert property ($rose(nrst) // RULE3
        |-> stack_pointer == 8'h07)
        else $error("stack pointer reset value wrong");
    carry_update_a: assert property (flag_upd.we && md_op == md_idle // RULE4
        |=> carry_flag == $past(flag_upd.cy)
            && half_carry_flag == $past(flag_upd.ac)) // RULE5
        else $error("carry flags not updated");
    bank_map_a: assert property ( // RULE6
        work_reg_addr == 8'(bank_select_field * 8 + work_reg_idx))
        else $error("bank mapping wrong");
    parity_view_a: assert property ( // RULE8
        program_status_word[0] == ^accumulator)
        else $error("parity flag wrong");
    mul_narrow_a: assert property ( // RULE12
        md_op == md_mul && !multiply_mode_bit
        |=> {b_reg, accumulator} == $past(accumulator) * $past(b_reg))
        else $error("8-bit multiply wrong");
    div_narrow_a: assert property ( // RULE14
        md_op == md_div && !divide_mode_bit && b_reg != 8'h00
        |=> accumulator == $past(accumulator) / $past(b_reg)
            && b_reg == $past(accumulator) % $past(b_reg))
        else $error("8-bit divide wrong");
    mode_reset_a: assert property ($rose(nrst) // RULE11
        |-> !multiply_mode_bit && !divide_mode_bit)
        else $error("mode not 8-bit after reset");
    ptr_select_a: assert property ( // RULE16
        ptr_inc && !ptr_load && !sfr_wr_at(sfr_req, `OFF_CPU_MODE_SELECT)
        |=> active_ptr == $past(active_ptr) + 16'h0001)
        else $error("selected pointer not incremented");
    page_high_a: assert property (ext_via_page // RULE21
        |-> ext_addr.addr[15:8] == external_ram_page)
        else $error("page byte not used");
    sfr_space_a: assert property (int_addr[7] && int_indirect // RULE20
        |-> !int_to_sfr)
        else $error("indirect access reached SFR");

endmodule : cpu_core_registers_muldiv

/* File: cpu_core_registers_muldiv_bench.sv */
// Self-checking bench for the core register block
`timescale 1ns/10ps
`include "core_regs_map.svh"

module cpu_core_registers_muldiv_bench import core_regs_pkg::*;;
    logic        core_clk;
    logic        nrst;
    sfr_req_s    sfr_req;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    logic        stack_push;
    logic        stack_pop;
    logic [7:0]  stack_addr;
    flag_upd_s   flag_upd;
    md_op_e      md_op;
    logic        md_done;
    logic        ptr_inc;
    logic        ptr_load;
    logic [15:0] ptr_load_val;
    logic [15:0] active_ptr;
    logic [7:0]  int_addr;
    logic        int_indirect;
    logic [2:0]  work_reg_idx;
    logic        int_to_sfr;
    logic [7:0]  work_reg_addr;
    logic [15:0] ext_in_addr;
    logic        ext_via_page;
    ext_addr_s   ext_addr;
    logic [7:0]  accumulator;
    logic [7:0]  program_status_word;
    int          err_count;
    int          compares;
    int unsigned seed;
    logic [7:0]  a, b, c, m;
    logic [24:0] e;
    logic [15:0] edges [4] = '{16'h04FF, 16'h0500, 16'h051F, 16'h0520};

    cpu_core_registers_muldiv uut (
        .core_clk, .nrst, .sfr_req, .sfr_rdata, .sfr_hit,
        .stack_push, .stack_pop, .stack_addr, .flag_upd, .md_op, .md_done,
        .ptr_inc, .ptr_load, .ptr_load_val, .active_ptr,
        .int_addr, .int_indirect, .work_reg_idx, .int_to_sfr,
        .work_reg_addr, .ext_in_addr, .ext_via_page, .ext_addr,
        .accumulator, .program_status_word
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask : step

    task automatic check(input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] ad, d);
        sfr_req = '{ad, 1'b1, 1'b0, d};
        step();
        sfr_req.wr = 1'b0;
        step();
    endtask : wr

    task automatic rd(input logic [7:0] ad, exp, input logic hit);
        sfr_req = '{ad, 1'b0, 1'b1, 8'h00};
        step();
        check(sfr_rdata, exp);
        check(sfr_hit, hit);
        sfr_req.rd = 1'b0;
        step();
    endtask : rd

    task automatic stk(input logic up, input logic [7:0] exp);
        stack_push = up;
        stack_pop = !up;
        #1;
        check(stack_addr, exp);
        step();
        stack_push = 1'b0;
        stack_pop = 1'b0;
        step();
    endtask : stk

    task automatic run_md(input md_op_e op);
        md_op = op;
        step();
        check(md_done, 1'b1);
        md_op = md_idle;
        step();
        check(md_done, 1'b0);
    endtask : run_md

    task automatic do_reset();
        nrst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        nrst = 1'b1;
    endtask : do_reset

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Expected {ov, aux, b, a} after one multiply or divide
    function automatic logic [24:0] md_exp(input logic dv, w,
                                           input logic [7:0] c, a, b);
        logic [23:0] p;
        p = w ? {c, a} : {8'h00, a};
        if (!dv) begin
            p = p * b;
            return {w ? |p[23:16] : |p[15:8], w ? p[23:16] : c, p[15:0]};
        end
        if (b == 8'h00) return {1'b1, w ? 8'h00 : c, 16'h0000};
        return {1'b0, w ? 8'(p / b >> 8) : c, 8'(p % b), 8'(p / b)};
    endfunction : md_exp

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sfr_req, stack_push, stack_pop, flag_upd, ptr_inc, ptr_load} = '0;
        {ptr_load_val, int_addr, int_indirect, work_reg_idx} = '0;
        {ext_in_addr, ext_via_page} = '0;
        md_op = md_idle;
        err_count = 0;
        compares = 0;
        seed = $urandom(27730);
        do_reset();
        rd(`OFF_STACK_POINTER, `RST_STACK_POINTER, 1'b1);
        rd(`OFF_CPU_MODE_SELECT, 8'h00, 1'b1);
        rd(`OFF_PROGRAM_STATUS, 8'h00, 1'b1);
        rd(8'h80, 8'h00, 1'b0);
        stk(1'b1, 8'h08);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            {a, b} = 16'($urandom);
            b[4:3] = 2'(i >> 2);
            work_reg_idx = 3'(i);
            wr(`OFF_ACCUMULATOR, a);
            wr(`OFF_PROGRAM_STATUS, b);
            rd(`OFF_PROGRAM_STATUS, {b[7:1], ^a}, 1'b1);
            check(work_reg_addr, {3'b000, b[4:3], 3'(i)});
        end
        for (int i = 0; i < 8; i++) begin
            flag_upd = '{1'b1, i[0], i[1], i[2]};
            step();
            flag_upd.we = 1'b0;
            check(program_status_word[7], i[0]);
            check(program_status_word[6], i[1]);
            check(program_status_word[2], i[2]);
            step();
        end
        $display("status test done");
        wr(`OFF_STACK_POINTER, 8'hFE);
        stk(1'b1, 8'hFF);
        stk(1'b1, 8'h00);
        stk(1'b0, 8'h00);
        rd(`OFF_STACK_POINTER, 8'hFF, 1'b1);
        $display("stack test done");
        wr(`OFF_PTR0_LOW, 8'h34);
        wr(`OFF_PTR0_HIGH, 8'h12);
        wr(`OFF_PTR1_LOW, 8'hFF);
        wr(`OFF_PTR1_HIGH, 8'hAB);
        check(active_ptr, 16'h1234);
        wr(`OFF_CPU_MODE_SELECT, 8'hBF);
        rd(`OFF_CPU_MODE_SELECT, `MASK_CPU_MODE, 1'b1);
        check(active_ptr, 16'hABFF);
        ptr_inc = 1'b1;
        step();
        ptr_inc = 1'b0;
        step();
        rd(`OFF_PTR1_HIGH, 8'hAC, 1'b1);
        ptr_load_val = 16'($urandom);
        ptr_load = 1'b1;
        step();
        ptr_load = 1'b0;
        check(active_ptr, ptr_load_val);
        step();
        wr(`OFF_CPU_MODE_SELECT, 8'h00);
        check(active_ptr, 16'h1234);
        $display("pointer test done");
        for (int i = 0; i < 32; i++) begin
            {int_indirect, int_addr} = 9'($urandom);
            if (i < 4) int_addr = i[0] ? 8'h80 : 8'h7F;
            step();
            check(int_to_sfr, !int_indirect && int_addr >= 8'h80);
        end
        wr(`OFF_EXT_RAM_PAGE, 8'hFF);
        rd(`OFF_EXT_RAM_PAGE, `MASK_EXT_PAGE, 1'b1);
        for (int i = 0; i < 24; i++) begin
            ext_in_addr = i < 4 ? edges[i] : 16'($urandom_range(1535));
            ext_via_page = 1'b0;
            step();
            check(ext_addr.display, ext_in_addr[15:5] == 11'h028);
            check(ext_addr.in_range, ext_in_addr < 16'h0520);
            ext_via_page = 1'b1;
            step();
            check(ext_addr.addr, {8'h7F, ext_in_addr[7:0]});
        end
        $display("address test done");
        for (int i = 0; i < 32; i++) begin
            m = i[1] ? 8'h0C : 8'h00;
            {a, b, c} = 24'($urandom);
            if (i < 4) b = 8'h00;
            if (i >= 4 && i < 8) {a, b, c} = 24'hFFFFFF;
            wr(`OFF_CPU_MODE_SELECT, m);
            wr(`OFF_ACCUMULATOR, a);
            wr(`OFF_B_REGISTER, b);
            wr(`OFF_AUX_OPERAND, c);
            e = md_exp(i[0], i[1], c, a, b);
            run_md(i[0] ? md_div : md_mul);
            check(accumulator, e[7:0]);
            rd(`OFF_B_REGISTER, e[15:8], 1'b1);
            rd(`OFF_AUX_OPERAND, e[23:16], 1'b1);
            check(program_status_word[7], 1'b0);
            check(program_status_word[2], e[24]);
        end
        $display("multiply divide test done");
        do_reset();
        rd(`OFF_CPU_MODE_SELECT, 8'h00, 1'b1);
        rd(`OFF_STACK_POINTER, `RST_STACK_POINTER, 1'b1);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : cpu_core_registers_muldiv_bench
